// >>> design/uad_cfg.svh
// register offsets, field positions, reset values and timing counts of the detect core
`ifndef UAD_CFG_SVH
`define UAD_CFG_SVH
`define UAD_ADDR_CONTROL 8'h02
`define UAD_ADDR_EVENTS 8'h03
`define UAD_ADDR_EVMASK 8'h04
`define UAD_ADDR_STATUS 8'h05
`define UAD_ADDR_RCODE 8'h06
`define UAD_ADDR_TIMING 8'h07
`define UAD_ADDR_MANSW 8'h08
`define UAD_CTL_INTMASK 0
`define UAD_CTL_MANEN 2
`define UAD_CTL_IDDIS 3
`define UAD_CTL_SOFTRST 6
`define UAD_CTL_RESET 8'h05
`define UAD_MANSW_RESET 8'h07
`define UAD_EVMASK_RESET 8'h00
`define UAD_TIMING_RESET 8'h03
`define UAD_FET_CLOSED 2'h3
`define UAD_HOST1_SW 8'h04
`define UAD_EV_RCHANGE 0
`define UAD_EV_VBCHANGE 1
`define UAD_EV_ATTACH 2
`define UAD_EV_DETACH 3
`define UAD_RCODE_FLOAT 5'h00
`define UAD_RCODE_RIDA 5'h0A
`define UAD_RCODE_MAX 5'h16
`define UAD_CLK_HZ 40000000
`define UAD_BUS_HOLD_MS 30
`define UAD_BUS_HOLD_CYC ((`UAD_BUS_HOLD_MS * `UAD_CLK_HZ) / 1000)
`define UAD_RDET_UNIT_US 100
`define UAD_RDET_UNIT_CYC ((`UAD_RDET_UNIT_US * (`UAD_CLK_HZ / 1000000)))
`define UAD_SAMPLES_FIRST 3
`define UAD_SAMPLES_AFTER 2
`endif

// >>> design/uad_pkg.sv
// types shared by the detect core and the baseband controller
package uad_pkg;
    typedef enum logic [2:0] {
        UAD_ST_STANDBY = 3'b001,
        UAD_ST_DETECT = 3'b010,
        UAD_ST_ATTACHED = 3'b100
    } uad_det_type;
    typedef enum logic [3:0] {
        UAD_DS_IDLE = 4'b0001,
        UAD_DS_RUN = 4'b0010,
        UAD_DS_HALT = 4'b0100,
        UAD_DS_DONE = 4'b1000
    } uad_disc_type;
    typedef enum logic [2:0] {
        UAD_HS_IDLE = 3'b001,
        UAD_HS_READ = 3'b010,
        UAD_HS_HOLD = 3'b100
    } uad_host_type;
endpackage : uad_pkg

// >>> design/uad_link_if.sv
// link between baseband controller and detect core
`timescale 1ns/1ps
interface uad_link_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic scl;
    logic sda;
    logic irq_out_n;
    modport device (input addr, input wdata, input wr, input rd, output rdata,
                    input scl, input sda, output irq_out_n);
    modport host (output addr, output wdata, output wr, output rd, input rdata,
                  output scl, output sda, input irq_out_n);
endinterface : uad_link_if

// >>> design/uad_host.sv
// baseband controller end: drives register accesses and bus-hold reset on the link
`timescale 1ns/1ps
`include "uad_cfg.svh"
module uad_host #(
    parameter int unsigned HOLD_CYC = `UAD_BUS_HOLD_CYC + 16
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [1:0] cfg_addr_i,
    input wire logic [7:0] cfg_wdata_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    output logic [7:0] cfg_rdata_o,
    uad_link_if.host link
);
    typedef struct packed {
        uad_pkg::uad_host_type st;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [7:0] cfg_rdata;
        logic wr;
        logic rd;
        logic hold;
        logic [31:0] cnt;
        logic irq_s1;
        logic irq_s2;
    } uad_hstate_type;
    uad_hstate_type s_r;
    uad_hstate_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.wr = 1'b0;
        s_nxt.rd = 1'b0;
        s_nxt.irq_s1 = link.irq_out_n;
        s_nxt.irq_s2 = s_r.irq_s1;
        s_nxt.cfg_rdata = 8'h00;
        case (cfg_addr_i)
            2'h0: s_nxt.cfg_rdata = s_r.addr;
            2'h1: s_nxt.cfg_rdata = s_r.wdata;
            2'h2: s_nxt.cfg_rdata = s_r.rdata;
            default: s_nxt.cfg_rdata = {5'h00, ~s_r.irq_s2, s_r.hold, s_r.st != uad_pkg::UAD_HS_IDLE};
        endcase
        if (!cfg_rd_i) begin
            s_nxt.cfg_rdata = 8'h00;
        end
        case (s_r.st)
            uad_pkg::UAD_HS_IDLE: begin
                if (cfg_wr_i && cfg_addr_i == 2'h0) begin
                    s_nxt.addr = cfg_wdata_i;
                end
                if (cfg_wr_i && cfg_addr_i == 2'h1) begin
                    s_nxt.wdata = cfg_wdata_i;
                end
                if (cfg_wr_i && cfg_addr_i == 2'h3) begin
                    if (cfg_wdata_i[2]) begin
                        // both lines low long enough to force a device reset
                        s_nxt.hold = 1'b1;
                        s_nxt.cnt = 32'h00000000;
                        s_nxt.st = uad_pkg::UAD_HS_HOLD;
                    end else if (cfg_wdata_i[1]) begin
                        s_nxt.rd = 1'b1;
                        s_nxt.st = uad_pkg::UAD_HS_READ;
                    end else if (cfg_wdata_i[0]) begin
                        s_nxt.wr = 1'b1;
                    end
                end
            end
            uad_pkg::UAD_HS_READ: begin
                // core answers the cycle after the strobe, not with it
                if (!s_r.rd) begin
                    s_nxt.rdata = link.rdata;
                    s_nxt.st = uad_pkg::UAD_HS_IDLE;
                end
            end
            uad_pkg::UAD_HS_HOLD: begin
                s_nxt.cnt = s_r.cnt + 32'h00000001;
                if (s_r.cnt >= HOLD_CYC) begin
                    s_nxt.hold = 1'b0;
                    s_nxt.st = uad_pkg::UAD_HS_IDLE;
                end
            end
            default: s_nxt.st = uad_pkg::UAD_HS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r <= '0;
            s_r.st <= uad_pkg::UAD_HS_IDLE;
            s_r.irq_s1 <= 1'b1;
            s_r.irq_s2 <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.addr = s_r.addr;
    assign link.wdata = s_r.wdata;
    assign link.wr = s_r.wr;
    assign link.rd = s_r.rd;
    assign link.scl = ~s_r.hold;
    assign link.sda = ~s_r.hold;
    assign cfg_rdata_o = s_r.cfg_rdata;
endmodule : uad_host

// >>> design/uad_device.sv
// accessory detect core: resets, power gating, interrupts, id classification, switch control
// Overview of operation
// - power-up hardware reset loads all defaults
// - power-on reset on supply edges listed
// - both bus lines low 30ms resets
// - writing control bit 6 soft-resets
// - soft reset spares control and manual registers
// - after reset standby watches vbus and id
// - attach with valid vbus closes fet
// - registers need io supply; detection needs power
// - reset sets global mask, irq high
// - unmasked event drives irq low; read clears
// - separate per-source interrupt mask register
// - vbus valid only above 4.0 V
// - id and vbus changes raise events
// - initial id needs three agreeing samples
// - after attach two agreeing samples suffice
// - detect-disable (once attached) and float stop measurement
// - discovery once per vbus attach
// - measured id halts discovery except rid-a
// - manual enable applies manual switch register
// - default host1 switches close on attach
// - detach opens everything, flags id change
// - resistor code updates, codes 0 to 22
// - host clears mask, programs switches open
// - manual enable defaults to one
`timescale 1ns/1ps
`include "uad_cfg.svh"
module uad_device #(
    parameter int unsigned HOLD_CYC = `UAD_BUS_HOLD_CYC,
    parameter int unsigned UNIT_CYC = `UAD_RDET_UNIT_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic vbus_above_4v0_i,
    input wire logic vbat_valid_i,
    input wire logic vbat_below_1v0_i,
    input wire logic host_io_supply_i,
    input wire logic id_pin_floating_i,
    input wire logic [4:0] id_adc_code_i,
    input wire logic disc_stage_end_i,
    input wire logic disc_finished_i,
    output logic id_meas_enable_o,
    output logic disc_run_o,
    output logic fet_close_o,
    output logic [7:0] switch_state_o,
    output logic [4:0] resistor_code_o,
    uad_link_if.device link
);
    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
        logic [4:0] code_s1;
        logic [4:0] code_s2;
        logic vbus_d;
        logic vbat_d;
        logic io_d;
        logic float_d;
        logic [31:0] hold_cnt;
        logic [7:0] control;
        logic [7:0] mansw;
        logic [7:0] events;
        logic [7:0] evmask;
        logic [7:0] timing;
        logic [4:0] rcode;
        logic [4:0] last_code;
        logic [1:0] agree;
        logic [31:0] tick_cnt;
        uad_pkg::uad_det_type det;
        uad_pkg::uad_disc_type disc;
        logic fet;
        logic [7:0] sw;
        logic [7:0] rdata;
    } uad_dstate_type;
    uad_dstate_type s_r;
    uad_dstate_type s_nxt;

    logic vbus_ok;
    logic vbat_ok;
    logic io_ok;
    logic id_pin_floating;
    logic bus_low;
    logic hw_rst;
    logic sw_rst;
    logic attach_now;
    logic man_en;
    logic [7:0] set_ev;
    logic sample_tick;
    logic [1:0] need;
    logic [31:0] interval;

    // second sync stage only; first stage feeds nothing else
    assign vbus_ok = s_r.s2[0];
    assign vbat_ok = s_r.s2[1];
    assign io_ok = s_r.s2[2];
    assign id_pin_floating = s_r.s2[3];
    assign bus_low = ~s_r.s2[4] & ~s_r.s2[5];
    assign man_en = s_r.control[`UAD_CTL_MANEN];
    assign interval = ({24'h000000, s_r.timing} + 32'h00000001) * UNIT_CYC[31:0];
    assign sample_tick = s_r.tick_cnt >= interval - 32'h00000001;
    assign need = (s_r.det == uad_pkg::UAD_ST_ATTACHED) ? 2'(`UAD_SAMPLES_AFTER) : 2'(`UAD_SAMPLES_FIRST);
    assign attach_now = ~id_pin_floating | vbus_ok;

    always_comb begin
        s_nxt = s_r;
        set_ev = 8'h00;
        s_nxt.s1 = {vbat_below_1v0_i, link.sda, link.scl, id_pin_floating_i, host_io_supply_i, vbat_valid_i,
            vbus_above_4v0_i};
        s_nxt.s2 = s_r.s1;
        s_nxt.code_s1 = id_adc_code_i;
        s_nxt.code_s2 = s_r.code_s1;
        s_nxt.vbus_d = vbus_ok;
        s_nxt.vbat_d = vbat_ok;
        s_nxt.io_d = io_ok;
        s_nxt.float_d = id_pin_floating;
        // battery-low strap synced beside vbus so strap and edge line up
        hw_rst = (vbus_ok & ~s_r.vbus_d & s_r.s2[6])
            | (vbat_ok & ~s_r.vbat_d & ~vbus_ok)
            | (~io_ok & s_r.io_d);
        s_nxt.hold_cnt = bus_low ? s_r.hold_cnt + 32'h00000001 : 32'h00000000;
        if (bus_low && s_r.hold_cnt >= HOLD_CYC - 1) begin
            hw_rst = 1'b1;
            s_nxt.hold_cnt = 32'h00000000;
        end
        // register port is dead while the io supply is absent
        sw_rst = io_ok & link.wr & (link.addr == `UAD_ADDR_CONTROL) & link.wdata[`UAD_CTL_SOFTRST];
        s_nxt.rdata = 8'h00;
        if (io_ok && link.rd) begin
            case (link.addr)
                `UAD_ADDR_CONTROL: s_nxt.rdata = s_r.control;
                `UAD_ADDR_EVENTS: s_nxt.rdata = s_r.events;
                `UAD_ADDR_EVMASK: s_nxt.rdata = s_r.evmask;
                `UAD_ADDR_STATUS: s_nxt.rdata = {5'h00, s_r.det == uad_pkg::UAD_ST_ATTACHED, id_pin_floating, vbus_ok};
                `UAD_ADDR_RCODE: s_nxt.rdata = {3'h0, s_r.rcode};
                `UAD_ADDR_TIMING: s_nxt.rdata = s_r.timing;
                `UAD_ADDR_MANSW: s_nxt.rdata = s_r.mansw;
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        if (io_ok && link.wr) begin
            case (link.addr)
                `UAD_ADDR_CONTROL: s_nxt.control = {1'b0, link.wdata[6:0]} & 8'hBF;
                `UAD_ADDR_EVMASK: s_nxt.evmask = link.wdata;
                `UAD_ADDR_TIMING: s_nxt.timing = link.wdata;
                `UAD_ADDR_MANSW: s_nxt.mansw = link.wdata;
                default: s_nxt.control = s_nxt.control;
            endcase
        end
        // detection runs on battery or bus power alone
        s_nxt.tick_cnt = sample_tick ? 32'h00000000 : s_r.tick_cnt + 32'h00000001;
        if (!(vbus_ok || vbat_ok)) begin
            s_nxt.det = uad_pkg::UAD_ST_STANDBY;
            s_nxt.tick_cnt = 32'h00000000;
        end else begin
            case (s_r.det)
                uad_pkg::UAD_ST_STANDBY: begin
                    s_nxt.agree = 2'h0;
                    if (attach_now) begin
                        s_nxt.det = uad_pkg::UAD_ST_DETECT;
                        set_ev[`UAD_EV_VBCHANGE] = vbus_ok ^ s_r.vbus_d;
                    end
                end
                uad_pkg::UAD_ST_DETECT, uad_pkg::UAD_ST_ATTACHED: begin
                    if (vbus_ok != s_r.vbus_d) begin
                        set_ev[`UAD_EV_VBCHANGE] = 1'b1;
                    end
                    if (id_pin_floating != s_r.float_d) begin
                        s_nxt.agree = 2'h0;
                        if (id_pin_floating) begin
                            // float is watched even with measurement disabled
                            s_nxt.rcode = `UAD_RCODE_FLOAT;
                            set_ev[`UAD_EV_RCHANGE] = s_r.rcode != `UAD_RCODE_FLOAT;
                        end
                    end else if (sample_tick && id_meas_enable_o) begin
                        s_nxt.last_code = s_r.code_s2;
                        s_nxt.agree = (s_r.code_s2 == s_r.last_code && s_r.agree != 2'h3) ? s_r.agree + 2'h1 : 2'h1;
                        if (s_nxt.agree >= need && s_r.code_s2 <= `UAD_RCODE_MAX) begin
                            if (s_r.code_s2 != s_r.rcode) begin
                                s_nxt.rcode = s_r.code_s2;
                                set_ev[`UAD_EV_RCHANGE] = 1'b1;
                            end
                        end
                    end
                    if (s_r.det == uad_pkg::UAD_ST_DETECT && (vbus_ok || s_nxt.agree >= need)) begin
                        s_nxt.det = uad_pkg::UAD_ST_ATTACHED;
                        set_ev[`UAD_EV_ATTACH] = 1'b1;
                        s_nxt.sw = man_en ? {s_r.mansw[7:2], 2'h0} : `UAD_HOST1_SW;
                    end
                    if (!attach_now) begin
                        // detach wins over manual mode
                        s_nxt.det = uad_pkg::UAD_ST_STANDBY;
                        s_nxt.sw = 8'h00;
                        s_nxt.rcode = `UAD_RCODE_FLOAT;
                        set_ev[`UAD_EV_DETACH] = 1'b1;
                        set_ev[`UAD_EV_RCHANGE] = ~s_r.float_d | (s_r.rcode != `UAD_RCODE_FLOAT);
                    end
                end
                default: s_nxt.det = uad_pkg::UAD_ST_STANDBY;
            endcase
        end
        if (s_r.det == uad_pkg::UAD_ST_ATTACHED && man_en && attach_now && !s_r.control[`UAD_CTL_MANEN - 1]) begin
            s_nxt.sw = {s_r.mansw[7:2], 2'h0};
        end
        s_nxt.fet = (s_nxt.det != uad_pkg::UAD_ST_STANDBY) & vbus_ok
            & ~(man_en & (s_r.mansw[1:0] != `UAD_FET_CLOSED));
        case (s_r.disc)
            uad_pkg::UAD_DS_IDLE: if (vbus_ok && !s_r.vbus_d) s_nxt.disc = uad_pkg::UAD_DS_RUN;
            uad_pkg::UAD_DS_RUN: begin
                if (disc_finished_i) begin
                    s_nxt.disc = uad_pkg::UAD_DS_DONE;
                end else if (disc_stage_end_i && !id_pin_floating && s_r.rcode != `UAD_RCODE_FLOAT
                             && s_r.rcode != `UAD_RCODE_RIDA) begin
                    s_nxt.disc = uad_pkg::UAD_DS_HALT;
                end
            end
            uad_pkg::UAD_DS_HALT: if (id_pin_floating || s_r.rcode == `UAD_RCODE_RIDA) s_nxt.disc = uad_pkg::UAD_DS_RUN;
            uad_pkg::UAD_DS_DONE: s_nxt.disc = uad_pkg::UAD_DS_DONE;
            default: s_nxt.disc = uad_pkg::UAD_DS_IDLE;
        endcase
        if (!vbus_ok) begin
            s_nxt.disc = uad_pkg::UAD_DS_IDLE;
        end
        // set beats the clear-on-read in the same cycle
        s_nxt.events = ((io_ok && link.rd && link.addr == `UAD_ADDR_EVENTS) ? 8'h00 : s_r.events) | set_ev;
        if (sw_rst) begin
            s_nxt.events = 8'h00;
            s_nxt.evmask = `UAD_EVMASK_RESET;
            s_nxt.timing = `UAD_TIMING_RESET;
            s_nxt.rcode = `UAD_RCODE_FLOAT;
            s_nxt.det = uad_pkg::UAD_ST_STANDBY;
            s_nxt.disc = uad_pkg::UAD_DS_IDLE;
            s_nxt.sw = 8'h00;
            s_nxt.fet = 1'b0;
            s_nxt.agree = 2'h0;
        end
    end

    always_comb begin
        id_meas_enable_o = (s_r.det != uad_pkg::UAD_ST_STANDBY) & ~id_pin_floating
            & ~(s_r.det == uad_pkg::UAD_ST_ATTACHED & s_r.control[`UAD_CTL_IDDIS]);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || hw_rst) begin
            s_r <= '0;
            s_r.s1 <= {s_nxt.s1};
            s_r.s2 <= s_nxt.s2;
            s_r.vbus_d <= s_nxt.vbus_d;
            s_r.vbat_d <= s_nxt.vbat_d;
            s_r.io_d <= s_nxt.io_d;
            s_r.float_d <= 1'b1;
            s_r.control <= `UAD_CTL_RESET;
            s_r.mansw <= `UAD_MANSW_RESET;
            s_r.timing <= `UAD_TIMING_RESET;
            s_r.evmask <= `UAD_EVMASK_RESET;
            s_r.det <= uad_pkg::UAD_ST_STANDBY;
            s_r.disc <= uad_pkg::UAD_DS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.rdata = s_r.rdata;
    assign link.irq_out_n = ~(io_ok & ~s_r.control[`UAD_CTL_INTMASK] & |(s_r.events & ~s_r.evmask));
    assign disc_run_o = s_r.disc == uad_pkg::UAD_DS_RUN;
    assign fet_close_o = s_r.fet;
    assign switch_state_o = s_r.sw;
    assign resistor_code_o = s_r.rcode;
endmodule : uad_device

// >>> test/uad_link_sva.sv
// checker on the link between the baseband controller and the detect core
`timescale 1ns/1ps
`include "uad_cfg.svh"
module uad_link_sva #(
    parameter int unsigned HOLD_CYC = 20
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic scl,
    input wire logic sda,
    input wire logic irq_out_n
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // supply resets are invisible here, so this copy may read 0 while the core holds 1
    logic mask_r;
    logic [15:0] hold_cnt_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mask_r <= 1'b1;
            hold_cnt_r <= 16'h0000;
        end else begin
            if (wr && addr == `UAD_ADDR_CONTROL) begin
                mask_r <= wdata[`UAD_CTL_INTMASK];
            end
            if (scl || sda) begin
                hold_cnt_r <= 16'h0000;
            end else if (hold_cnt_r != 16'hFFFF) begin
                hold_cnt_r <= hold_cnt_r + 16'h0001;
            end
        end
    end
    AST_RST_IRQ_HIGH: assert property ($fell(srst_i) |-> irq_out_n)
        else $error("irq low right after reset");
    AST_MASK_IRQ_HIGH: assert property (mask_r |-> irq_out_n)
        else $error("irq low while global mask set");
    AST_READ_RELEASES_IRQ: assert property ((rd && addr == `UAD_ADDR_EVENTS) |=> irq_out_n)
        else $error("irq still low after event read");
    AST_SOFT_BIT_READS_ZERO: assert property ((rd && addr == `UAD_ADDR_CONTROL) |=> !rdata[6])
        else $error("soft reset bit read back as one");
    AST_RDATA_ONE_CYCLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data without a read");
    AST_SINGLE_STROBE: assert property (!(wr && rd))
        else $error("read and write strobes together");
    AST_HOLD_LONG_ENOUGH: assert property (($rose(scl) && hold_cnt_r != 16'h0000) |-> hold_cnt_r > HOLD_CYC)
        else $error("bus hold released too early");
    AST_HOLD_RESETS_CORE: assert property (($rose(scl) && hold_cnt_r > HOLD_CYC) |-> irq_out_n)
        else $error("irq low after bus hold reset");
    AST_LINES_TOGETHER: assert property (scl == sda)
        else $error("bus lines differ");
endmodule : uad_link_sva

// >>> test/tb_top.sv
// testbench: controller and detect core joined by the link, driven through the cfg port
`timescale 1ns/1ps
`include "uad_cfg.svh"
module tb_top;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [1:0] c_addr = 2'h0;
    logic [7:0] c_wdata = 8'h00;
    logic c_wr = 1'b0;
    logic c_rd = 1'b0;
    logic [7:0] c_rdata;
    logic vbus = 1'b0, vbat = 1'b1, vlow = 1'b0, io = 1'b1, flt = 1'b1, st_end = 1'b0, fin = 1'b0;
    logic [4:0] adc = 5'h00;
    logic meas, drun, fet;
    logic [7:0] sw;
    logic [4:0] rcode;
    logic [7:0] d;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    uad_link_if lk();
    uad_host #(.HOLD_CYC(36)) i_uad_host(.clk_i(clk_i), .srst_i(srst_i), .cfg_addr_i(c_addr),
        .cfg_wdata_i(c_wdata), .cfg_wr_i(c_wr), .cfg_rd_i(c_rd), .cfg_rdata_o(c_rdata), .link(lk));
    // short counts keep the run brief: sample interval is (3+1)*4 = 16 cycles
    uad_device #(.HOLD_CYC(20), .UNIT_CYC(4)) i_uad_device(.clk_i(clk_i), .srst_i(srst_i),
        .vbus_above_4v0_i(vbus), .vbat_valid_i(vbat), .vbat_below_1v0_i(vlow), .host_io_supply_i(io),
        .id_pin_floating_i(flt), .id_adc_code_i(adc), .disc_stage_end_i(st_end), .disc_finished_i(fin),
        .id_meas_enable_o(meas), .disc_run_o(drun), .fet_close_o(fet), .switch_state_o(sw),
        .resistor_code_o(rcode), .link(lk));
    uad_link_sva #(.HOLD_CYC(20)) i_uad_link_sva(.clk_i(clk_i), .srst_i(srst_i), .addr(lk.addr),
        .wdata(lk.wdata), .wr(lk.wr), .rd(lk.rd), .rdata(lk.rdata), .scl(lk.scl), .sda(lk.sda),
        .irq_out_n(lk.irq_out_n));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task end_of_test;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task cw(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_i);
        c_addr <= a;
        c_wdata <= v;
        c_wr <= 1'b1;
        @(posedge clk_i);
        c_wr <= 1'b0;
    endtask : cw
    task cr(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk_i);
        c_addr <= a;
        c_rd <= 1'b1;
        @(posedge clk_i);
        c_rd <= 1'b0;
        #1;
        v = c_rdata;
    endtask : cr
    // bounded poll of busy and hold flags
    task lwait;
        logic [7:0] s;
        int k;
        s = 8'hFF;
        for (k = 0; k < 100 && s[1:0] !== 2'b00; k++) begin
            cr(2'd3, s);
        end
        chk(s & 8'h03, 8'h00);
    endtask : lwait
    task lw(input logic [7:0] a, input logic [7:0] v);
        cw(2'd0, a);
        cw(2'd1, v);
        cw(2'd3, 8'h01);
        lwait();
    endtask : lw
    task lr(input logic [7:0] a, output logic [7:0] v);
        cw(2'd0, a);
        cw(2'd3, 8'h02);
        lwait();
        cr(2'd2, v);
    endtask : lr
    task rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        lr(a, v);
        chk(v, e);
    endtask : rchk
    initial begin
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk({7'h0, lk.irq_out_n}, 8'h01);
        rchk(`UAD_ADDR_CONTROL, `UAD_CTL_RESET);
        rchk(`UAD_ADDR_MANSW, `UAD_MANSW_RESET);
        rchk(`UAD_ADDR_TIMING, `UAD_TIMING_RESET);
        rchk(`UAD_ADDR_EVMASK, `UAD_EVMASK_RESET);
        rchk(8'h30, 8'h00);
        lw(`UAD_ADDR_MANSW, 8'h00);
        lw(`UAD_ADDR_CONTROL, 8'h00);
        @(posedge clk_i);
        vbus <= 1'b1;
        for (n = 0; n < 100 && (fet !== 1'b1 || sw !== `UAD_HOST1_SW); n++) @(posedge clk_i);
        chk({7'h0, fet}, 8'h01);
        chk(sw, `UAD_HOST1_SW);
        chk({7'h0, drun}, 8'h01);
        chk({7'h0, lk.irq_out_n}, 8'h00);
        lr(`UAD_ADDR_EVENTS, d);
        chk(d & 8'h02, 8'h02);
        rchk(`UAD_ADDR_STATUS, 8'h07);
        @(posedge clk_i);
        flt <= 1'b0;
        adc <= 5'd13;
        for (n = 0; n < 300 && rcode !== 5'd13; n++) @(posedge clk_i);
        chk({3'h0, rcode}, 8'h0D);
        chk({7'h0, meas}, 8'h01);
        @(posedge clk_i);
        st_end <= 1'b1;
        @(posedge clk_i);
        st_end <= 1'b0;
        for (n = 0; n < 10 && drun !== 1'b0; n++) @(posedge clk_i);
        chk({7'h0, drun}, 8'h00);
        lr(`UAD_ADDR_EVENTS, d);
        chk(d & 8'h01, 8'h01);
        lw(`UAD_ADDR_CONTROL, 8'h08);
        chk({7'h0, meas}, 8'h00);
        // manual mode with the fet field open, then closed
        lw(`UAD_ADDR_MANSW, 8'h04);
        lw(`UAD_ADDR_CONTROL, 8'h0C);
        chk({7'h0, fet}, 8'h00);
        lw(`UAD_ADDR_MANSW, 8'h07);
        chk({7'h0, fet}, 8'h01);
        @(posedge clk_i);
        flt <= 1'b1;
        vbus <= 1'b0;
        adc <= 5'h00;
        for (n = 0; n < 100 && (fet !== 1'b0 || sw !== 8'h00); n++) @(posedge clk_i);
        chk({7'h0, fet}, 8'h00);
        chk(sw, 8'h00);
        // late flags must land before the event read
        repeat (100) @(posedge clk_i);
        lr(`UAD_ADDR_EVENTS, d);
        chk(d & 8'h01, 8'h01);
        chk({3'h0, rcode}, 8'h00);
        chk({7'h0, drun}, 8'h00);
        lw(`UAD_ADDR_CONTROL, 8'h00);
        @(posedge clk_i);
        flt <= 1'b0;
        adc <= 5'd22;
        for (n = 0; n < 300 && rcode !== 5'd22; n++) @(posedge clk_i);
        chk({7'h0, (n > 32 && n < 100)}, 8'h01);
        for (n = 0; n < 20 && sw !== `UAD_HOST1_SW; n++) @(posedge clk_i);
        chk(sw, `UAD_HOST1_SW);
        chk({7'h0, fet}, 8'h00);
        repeat (50) @(posedge clk_i);
        lr(`UAD_ADDR_EVENTS, d);
        lw(`UAD_ADDR_EVMASK, 8'h0F);
        @(posedge clk_i);
        flt <= 1'b1;
        adc <= 5'h00;
        repeat (150) @(posedge clk_i);
        chk({7'h0, lk.irq_out_n}, 8'h01);
        lw(`UAD_ADDR_EVMASK, 8'h00);
        chk({7'h0, lk.irq_out_n}, 8'h00);
        cr(2'd3, d);
        chk(d & 8'h04, 8'h04);
        lr(`UAD_ADDR_EVENTS, d);
        lw(`UAD_ADDR_TIMING, 8'h05);
        lw(`UAD_ADDR_EVMASK, 8'hFF);
        lw(`UAD_ADDR_CONTROL, 8'h44);
        rchk(`UAD_ADDR_CONTROL, 8'h04);
        rchk(`UAD_ADDR_TIMING, `UAD_TIMING_RESET);
        rchk(`UAD_ADDR_EVMASK, `UAD_EVMASK_RESET);
        rchk(`UAD_ADDR_MANSW, 8'h07);
        // writes while the io supply is gone are dropped
        @(posedge clk_i);
        io <= 1'b0;
        repeat (4) @(posedge clk_i);
        lw(`UAD_ADDR_CONTROL, 8'h00);
        @(posedge clk_i);
        io <= 1'b1;
        repeat (4) @(posedge clk_i);
        rchk(`UAD_ADDR_CONTROL, `UAD_CTL_RESET);
        for (int k = 0; k < 2; k++) begin
            lw(`UAD_ADDR_CONTROL, 8'h00);
            @(posedge clk_i);
            vlow <= k[0];
            vbus <= k[0];
            vbat <= k[0];
            repeat (4) @(posedge clk_i);
            vbat <= 1'b1;
            repeat (4) @(posedge clk_i);
            rchk(`UAD_ADDR_CONTROL, `UAD_CTL_RESET);
            @(posedge clk_i);
            vbus <= 1'b0;
            vlow <= 1'b0;
            repeat (100) @(posedge clk_i);
        end
        // discovery runs once per vbus attach and stays finished
        @(posedge clk_i);
        vbus <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        chk({7'h0, drun}, 8'h01);
        @(posedge clk_i);
        fin <= 1'b1;
        @(posedge clk_i);
        fin <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        chk({7'h0, drun}, 8'h00);
        lw(`UAD_ADDR_CONTROL, 8'h00);
        cw(2'd3, 8'h04);
        lwait();
        rchk(`UAD_ADDR_CONTROL, `UAD_CTL_RESET);
        end_of_test();
    end
endmodule : tb_top
